// [common/gpc_defines.vh]
// constants for the glow plug control supervisor
`ifndef GPC_DEFINES_VH
`define GPC_DEFINES_VH
`define GPC_CLK_HZ 100000000
`define GPC_CI_FIL_US 20
`define GPC_CI_FIL_CYC ((`GPC_CI_FIL_US * (`GPC_CLK_HZ / 1000000)))
`define GPC_VS_FIL_US 100
`define GPC_VS_FIL_CYC ((`GPC_VS_FIL_US * (`GPC_CLK_HZ / 1000000)))
`define GPC_LD_US 100
`define GPC_LD_CYC ((`GPC_LD_US * (`GPC_CLK_HZ / 1000000)))
`define GPC_BAT_FIL_US 100
`define GPC_BAT_FIL_CYC ((`GPC_BAT_FIL_US * (`GPC_CLK_HZ / 1000000)))
`define GPC_CP_FIL_US 100
`define GPC_CP_FIL_CYC ((`GPC_CP_FIL_US * (`GPC_CLK_HZ / 1000000)))
`define GPC_TO_US 100000
`define GPC_TO_CYC ((`GPC_TO_US * (`GPC_CLK_HZ / 1000000)))
`define GPC_SUP_US 2500
`define GPC_SUP_CYC ((`GPC_SUP_US * (`GPC_CLK_HZ / 1000000)))
`define GPC_MODE_W 3
`define GPC_MODE_1 3'h1
`define GPC_MODE_2 3'h2
`define GPC_MODE_3 3'h3
`define GPC_MODE_4 3'h4
`define GPC_MODE_5 3'h5
`define GPC_MODE_6 3'h6
`define GPC_CNT_W 32
`endif

// [design/gpc_filter.v]
// level filter: output follows input once stable for LIMIT cycles
`timescale 1ns/10ps
`default_nettype none
module gpc_filter #(
  parameter [31:0] LIMIT = 32'h0000_0001,
  parameter RST_VAL = 1'b0
) (
  // clock and reset
  input wire sys_clk_i,
  input wire rst_n_i,
  // level in and filtered out
  input wire d_i,
  output reg q_o
);
  reg [31:0] cnt_reg;
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_reg <= 32'h0000_0000;
      q_o <= RST_VAL;
    end else if (d_i == q_o) begin
      cnt_reg <= 32'h0000_0000;
    end else if (cnt_reg >= LIMIT - 32'h0000_0001) begin
      cnt_reg <= 32'h0000_0000;
      q_o <= d_i;
    end else begin
      cnt_reg <= cnt_reg + 32'h0000_0001;
    end
  end
endmodule
`default_nettype wire

// [design/gpc_top.v]
// glow plug control supervisor: mode decode, control input, supply guard
`timescale 1ns/10ps
`default_nettype none
`include "gpc_defines.vh"
module gpc_top #(
  parameter [31:0] TO_CYC = `GPC_TO_CYC,
  parameter [31:0] SUP_CYC = `GPC_SUP_CYC,
  parameter [31:0] CI_FIL_CYC = `GPC_CI_FIL_CYC,
  parameter [31:0] VS_FIL_CYC = `GPC_VS_FIL_CYC,
  parameter [31:0] LD_CYC = `GPC_LD_CYC,
  parameter [31:0] BAT_FIL_CYC = `GPC_BAT_FIL_CYC,
  parameter [31:0] CP_FIL_CYC = `GPC_CP_FIL_CYC
) (
  // clock and reset
  input wire sys_clk_i,
  input wire rst_n_i,
  // mode straps
  input wire ms_open_i,
  input wire ms_cur_i,
  input wire bat_present_i,
  input wire io_cur_i,
  // control input, high = off level
  input wire control_input_pin_i,
  input wire ci_low_above_override_i,
  // analog comparators
  input wire vs_uv_i,
  input wire vs_ov_i,
  input wire vs_ld_i,
  input wire vs_ol_low_i,
  input wire vs_absent_i,
  input wire bat_uv_i,
  input wire cp_uv_i,
  // outputs
  output reg [`GPC_MODE_W-1:0] mode_o,
  output reg relay_mode_o,
  output reg serial_proto_o,
  output reg temp_comp_o,
  output reg power_reg_o,
  output reg switch_on_o,
  output reg relay_on_o,
  output reg ol_enable_o,
  output reg uv_fail_o,
  output reg ov_fail_o,
  output reg bat_uv_fail_o,
  output reg cp_uv_fail_o,
  output reg ci_fall_o,
  output reg meas_valid_o,
  output reg [31:0] on_time_o,
  output reg [31:0] period_o
);
  ////////////////////////////////////////////////////////////////////////
  function [`GPC_MODE_W-1:0] decode_mode;
    input ms_o;
    input ms_c;
    input battery_sense_pin;
    input io_c;
    begin
      if (!ms_o && !ms_c)
        decode_mode = battery_sense_pin ? `GPC_MODE_2 : `GPC_MODE_1;
      else if (ms_c)
        decode_mode = io_c ? `GPC_MODE_3 : `GPC_MODE_4;
      else
        decode_mode = io_c ? `GPC_MODE_5 : `GPC_MODE_6;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // reset release and input synchronisers
  reg [1:0] rst_sync_reg;
  wire rst_n;
  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i)
      rst_sync_reg <= 2'b00;
    else
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end
  assign rst_n = rst_sync_reg[1];

  localparam NSYNC = 13;
  wire [NSYNC-1:0] raw_in;
  reg [NSYNC-1:0] s1_reg;
  reg [NSYNC-1:0] s2_reg;
  assign raw_in = {ms_open_i, ms_cur_i, bat_present_i, io_cur_i,
                   control_input_pin_i, ci_low_above_override_i,
                   vs_uv_i, vs_ov_i, vs_ld_i, vs_ol_low_i, vs_absent_i,
                   bat_uv_i, cp_uv_i};
  // idle control level is off (high); pull-up modelled by reset value
  always @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg <= 13'h0100;
      s2_reg <= 13'h0100;
    end else begin
      s1_reg <= raw_in;
      s2_reg <= s1_reg;
    end
  end
  wire ms_o_s = s2_reg[12];
  wire ms_c_s = s2_reg[11];
  wire bat_s = s2_reg[10];
  wire io_c_s = s2_reg[9];
  wire ci_s = s2_reg[8];
  wire ovr_s = s2_reg[7];
  wire uv_s = s2_reg[6];
  wire ov_s = s2_reg[5];
  wire ld_s = s2_reg[4];
  wire ol_low_s = s2_reg[3];
  wire absent_s = s2_reg[2];
  wire bat_uv_s = s2_reg[1];
  wire cp_uv_s = s2_reg[0];

  ////////////////////////////////////////////////////////////////////////
  // filters
  wire ci_f;
  wire uv_f;
  wire ov_f;
  wire ld_f;
  wire bat_uv_f;
  wire cp_uv_f;
  gpc_filter #(.LIMIT(CI_FIL_CYC), .RST_VAL(1'b1)) u_ci_fil (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n), .d_i(ci_s), .q_o(ci_f));
  gpc_filter #(.LIMIT(VS_FIL_CYC), .RST_VAL(1'b0)) u_uv_fil (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n), .d_i(uv_s), .q_o(uv_f));
  gpc_filter #(.LIMIT(VS_FIL_CYC), .RST_VAL(1'b0)) u_ov_fil (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n), .d_i(ov_s), .q_o(ov_f));
  gpc_filter #(.LIMIT(LD_CYC), .RST_VAL(1'b0)) u_ld_fil (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n), .d_i(ld_s), .q_o(ld_f));
  gpc_filter #(.LIMIT(BAT_FIL_CYC), .RST_VAL(1'b0)) u_bat_fil (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n), .d_i(bat_uv_s),
    .q_o(bat_uv_f));
  gpc_filter #(.LIMIT(CP_FIL_CYC), .RST_VAL(1'b0)) u_cp_fil (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n), .d_i(cp_uv_s),
    .q_o(cp_uv_f));

  ////////////////////////////////////////////////////////////////////////
  // mode latch: straps read once, a few cycles after reset release
  reg [1:0] strap_cnt_reg;
  reg mode_valid_reg;
  reg [`GPC_MODE_W-1:0] mode_reg;
  always @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      strap_cnt_reg <= 2'b00;
      mode_valid_reg <= 1'b0;
      mode_reg <= `GPC_MODE_1;
    end else if (!mode_valid_reg) begin
      strap_cnt_reg <= strap_cnt_reg + 2'b01;
      if (strap_cnt_reg == 2'b11) begin
        mode_valid_reg <= 1'b1;
        mode_reg <= decode_mode(ms_o_s, ms_c_s, bat_s, io_c_s);
      end
    end
  end
  wire relay_m = (mode_reg == `GPC_MODE_1) || (mode_reg == `GPC_MODE_2);
  wire trans_m = !relay_m;
  wire ts_m = (mode_reg == `GPC_MODE_5) || (mode_reg == `GPC_MODE_6);
  wire preg_m = (mode_reg == `GPC_MODE_4) || (mode_reg == `GPC_MODE_6);
  wire aux_m = (mode_reg != `GPC_MODE_1);

  ////////////////////////////////////////////////////////////////////////
  // control edges and pulse-group logic
  reg ci_d_reg;
  reg on_req_reg;
  reg first_reg;
  reg hold_reg;
  reg [31:0] to_cnt_reg;
  reg [31:0] on_cnt_reg;
  reg [31:0] per_cnt_reg;
  reg meas_on_reg;
  wire fall = ci_d_reg && !ci_f;
  wire rise = !ci_d_reg && ci_f;
  always @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ci_d_reg <= 1'b1;
      on_req_reg <= 1'b0;
      first_reg <= 1'b1;
      hold_reg <= 1'b0;
      to_cnt_reg <= 32'h0000_0000;
      on_cnt_reg <= 32'h0000_0000;
      per_cnt_reg <= 32'h0000_0000;
      meas_on_reg <= 1'b0;
      on_time_o <= 32'h0000_0000;
      period_o <= 32'h0000_0000;
      meas_valid_o <= 1'b0;
      ci_fall_o <= 1'b0;
    end else begin
      ci_d_reg <= ci_f;
      ci_fall_o <= fall;
      meas_valid_o <= 1'b0;
      if (mode_valid_reg && trans_m) begin
        on_cnt_reg <= on_cnt_reg + 32'h0000_0001;
        per_cnt_reg <= per_cnt_reg + 32'h0000_0001;
        if (fall) begin
          if (meas_on_reg) begin
            period_o <= per_cnt_reg;
            meas_valid_o <= 1'b1;
          end
          meas_on_reg <= 1'b1;
          // the edge cycle itself counts as the first cycle of the interval
          on_cnt_reg <= 32'h0000_0001;
          per_cnt_reg <= 32'h0000_0001;
          to_cnt_reg <= 32'h0000_0000;
          on_req_reg <= 1'b1;
          hold_reg <= first_reg && ovr_s;
          first_reg <= 1'b0;
        end else begin
          if (rise) begin
            on_time_o <= on_cnt_reg;
            on_req_reg <= 1'b0;
            hold_reg <= 1'b0;
          end
          if (hold_reg && !ci_f)
            to_cnt_reg <= 32'h0000_0000;
          else if (to_cnt_reg >= TO_CYC - 32'h0000_0001) begin
            on_req_reg <= 1'b0;
            first_reg <= 1'b1;
            meas_on_reg <= 1'b0;
            to_cnt_reg <= 32'h0000_0000;
          end else if (on_req_reg || meas_on_reg)
            to_cnt_reg <= to_cnt_reg + 32'h0000_0001;
        end
      end else begin
        on_req_reg <= !ci_f;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // mode two relay pulse suppression: relay changes only after the
  // new level held for the suppress time, so short pulses vanish
  reg relay_f_reg;
  reg [31:0] sup_cnt_reg;
  always @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      relay_f_reg <= 1'b0;
      sup_cnt_reg <= 32'h0000_0000;
    end else if (relay_f_reg == !ci_f) begin
      sup_cnt_reg <= 32'h0000_0000;
    end else if (sup_cnt_reg >= SUP_CYC - 32'h0000_0001) begin
      sup_cnt_reg <= 32'h0000_0000;
      relay_f_reg <= !ci_f;
    end else begin
      sup_cnt_reg <= sup_cnt_reg + 32'h0000_0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // supply guard
  reg ld_on_reg;
  reg cp_lock_reg;
  always @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ld_on_reg <= 1'b0;
      cp_lock_reg <= 1'b0;
    end else begin
      if (ld_f)
        ld_on_reg <= 1'b1;
      else if (!ov_f && !ov_s)
        ld_on_reg <= 1'b0;
      // set wins over the fresh switch-on request
      if (cp_uv_f)
        cp_lock_reg <= 1'b1;
      else if (fall || (relay_m && rise == 1'b0 && ci_d_reg && !ci_f))
        cp_lock_reg <= 1'b0;
    end
  end
  // forced off releases on its own when uv, ov or supply absence clears; the charge pump lock waits for a falling control edge
  wire forced_off = uv_f || (ov_f && !ld_on_reg) || cp_lock_reg ||
                    (aux_m && absent_s);
  wire demand = (mode_reg == `GPC_MODE_1) ? !ci_f :
                (mode_reg == `GPC_MODE_2) ? relay_f_reg : on_req_reg;

  ////////////////////////////////////////////////////////////////////////
  // registered outputs
  always @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      mode_o <= `GPC_MODE_1;
      relay_mode_o <= 1'b0;
      serial_proto_o <= 1'b0;
      temp_comp_o <= 1'b0;
      power_reg_o <= 1'b0;
      switch_on_o <= 1'b0;
      relay_on_o <= 1'b0;
      ol_enable_o <= 1'b0;
      uv_fail_o <= 1'b0;
      ov_fail_o <= 1'b0;
      bat_uv_fail_o <= 1'b0;
      cp_uv_fail_o <= 1'b0;
    end else begin
      mode_o <= mode_reg;
      relay_mode_o <= relay_m;
      serial_proto_o <= (mode_reg != `GPC_MODE_1);
      temp_comp_o <= ts_m;
      power_reg_o <= preg_m;
      switch_on_o <= mode_valid_reg && trans_m &&
        (ld_on_reg || (demand && !forced_off));
      relay_on_o <= mode_valid_reg && relay_m &&
        (ld_on_reg || (demand && !forced_off));
      ol_enable_o <= !ol_low_s;
      uv_fail_o <= uv_f;
      ov_fail_o <= ov_f;
      bat_uv_fail_o <= aux_m && bat_uv_f;
      cp_uv_fail_o <= cp_lock_reg;
    end
  end
endmodule
`default_nettype wire

// [tb/gpc_top_asserts.sv]
// assertion checker bound to the glow plug control supervisor top
`timescale 1ns/10ps
`default_nettype none
`include "gpc_defines.vh"
module gpc_top_asserts #(
  parameter [31:0] TO_CYC = 32'h0000_00C8,
  parameter [31:0] CI_FIL_CYC = 32'h0000_0004
) (
  // clock, reset and watched inputs
  input wire sys_clk_i,
  input wire rst_n_i,
  input wire control_input_pin_i,
  input wire vs_ov_i,
  input wire vs_ol_low_i,
  input wire vs_absent_i,
  // watched outputs
  input wire [`GPC_MODE_W-1:0] mode_o,
  input wire relay_mode_o,
  input wire serial_proto_o,
  input wire temp_comp_o,
  input wire power_reg_o,
  input wire switch_on_o,
  input wire relay_on_o,
  input wire ol_enable_o,
  input wire uv_fail_o,
  input wire cp_uv_fail_o,
  input wire ci_fall_o
);
  logic [31:0] low_cnt_reg, fall_age_reg, ov_age_reg;
  wire decoded = relay_mode_o || serial_proto_o;
  ////////////////////////////////////////////////////////////////////////////
  // ages are 32 bits, so no wrap within any run
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      low_cnt_reg <= 32'h0000_0000;
      fall_age_reg <= 32'h0000_0000;
      ov_age_reg <= 32'h0000_0000;
    end else begin
      low_cnt_reg <= control_input_pin_i ? 32'h0000_0000 : low_cnt_reg + 1;
      fall_age_reg <= ci_fall_o ? 32'h0000_0000 : fall_age_reg + 1;
      ov_age_reg <= vs_ov_i ? 32'h0000_0000 : ov_age_reg + 1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  AST_FALL_FILT: assert property (ci_fall_o |-> low_cnt_reg >= CI_FIL_CYC)
    else $error("falling edge reported without filtered low");
  AST_FALL_PULSE: assert property (ci_fall_o |=> !ci_fall_o)
    else $error("falling edge pulse longer than one cycle");
  AST_RELAY_DEC: assert property (decoded |-> relay_mode_o == (mode_o < 3))
    else $error("relay mode flag disagrees with mode");
  AST_SERIAL: assert property (decoded |-> serial_proto_o == (mode_o != 1))
    else $error("protocol flag disagrees with mode");
  AST_SENSE_REG: assert property (decoded |-> temp_comp_o == (mode_o > 4) && power_reg_o == (mode_o == 4 || mode_o == 6))
    else $error("sense or regulation flag disagrees with mode");
  AST_TIMEOUT: assert property ((fall_age_reg > TO_CYC + 20 && ov_age_reg > 40 && control_input_pin_i && !relay_mode_o) |-> !switch_on_o)
    else $error("switches on after pulse group ended");
  AST_UV: assert property (uv_fail_o |-> !switch_on_o && !relay_on_o)
    else $error("plugs on during undervoltage");
  AST_ABSENT: assert property ((serial_proto_o && vs_absent_i) [*6] |-> !switch_on_o)
    else $error("switches on without main supply");
  AST_OL: assert property (vs_ol_low_i [*6] |-> !ol_enable_o)
    else $error("open-load detection enabled at low supply");
  AST_CP: assert property (cp_uv_fail_o |-> !switch_on_o)
    else $error("switches on during charge pump undervoltage");
endmodule
bind gpc_top gpc_top_asserts #(.TO_CYC(TO_CYC), .CI_FIL_CYC(CI_FIL_CYC)) u_chk (
  .sys_clk_i, .rst_n_i, .control_input_pin_i, .vs_ov_i, .vs_ol_low_i,
  .vs_absent_i, .mode_o, .relay_mode_o, .serial_proto_o, .temp_comp_o,
  .power_reg_o, .switch_on_o, .relay_on_o, .ol_enable_o, .uv_fail_o,
  .cp_uv_fail_o, .ci_fall_o);
`default_nettype wire

// [tb/gpc_ecu_model.sv]
// engine controller model driving the control input with pwm
`timescale 1ns/10ps
`default_nettype none
module gpc_ecu_model (
  // clock and run control
  input wire logic sys_clk_i,
  input wire logic en_i,
  // low and high lengths in cycles
  input wire logic [15:0] low_i,
  input wire logic [15:0] high_i,
  // control level, high is off
  output var logic ci_o
);
  logic [15:0] cnt_reg = 16'h0000;
  initial ci_o = 1'b1;
  always @(negedge sys_clk_i) begin
    if (!en_i) begin
      // released line rests at the pulled-up off level
      cnt_reg <= 16'h0000;
      ci_o <= 1'b1;
    end else begin
      ci_o <= (cnt_reg >= low_i);
      cnt_reg <= (cnt_reg == low_i + high_i - 1) ? 16'h0000 : cnt_reg + 1;
    end
  end
endmodule
`default_nettype wire

// [tb/tb_top.sv]
// self-checking bench for the glow plug control supervisor
`timescale 1ns/10ps
`default_nettype none
`include "gpc_defines.vh"
module tb_top;
  localparam int TO = 32'h0000_00C8;
  localparam int VF = 32'h0000_0008;
  logic sys_clk_i = 1'b0, rst_n_i = 1'b0, ms_open_i = 1'b0, ms_cur_i = 1'b0;
  logic bat_present_i = 1'b0, io_cur_i = 1'b0, ci_drv = 1'b1, ecu_en = 1'b0;
  logic ci_low_above_override_i = 1'b0, vs_uv_i = 1'b0, vs_ov_i = 1'b0;
  logic vs_ld_i = 1'b0, vs_ol_low_i = 1'b0, vs_absent_i = 1'b0;
  logic bat_uv_i = 1'b0, cp_uv_i = 1'b0, ecu_ci;
  logic [15:0] lo = 16'h0014, hi = 16'h001E;
  wire logic control_input_pin_i = ecu_en ? ecu_ci : ci_drv;
  logic [`GPC_MODE_W-1:0] mode_o;
  logic relay_mode_o, serial_proto_o, temp_comp_o, power_reg_o, switch_on_o;
  logic relay_on_o, ol_enable_o, uv_fail_o, ov_fail_o, bat_uv_fail_o;
  logic cp_uv_fail_o, ci_fall_o, meas_valid_o;
  logic [31:0] on_time_o, period_o;
  int n_errors = 0;
  int num_checks = 0;
  always #5 sys_clk_i = ~sys_clk_i;
  gpc_top #(.TO_CYC(TO), .SUP_CYC(32'h0000_0028), .CI_FIL_CYC(32'h0000_0004),
    .VS_FIL_CYC(VF), .LD_CYC(VF), .BAT_FIL_CYC(VF), .CP_FIL_CYC(VF)) dut (
    .sys_clk_i, .rst_n_i, .ms_open_i, .ms_cur_i, .bat_present_i, .io_cur_i,
    .control_input_pin_i, .ci_low_above_override_i, .vs_uv_i, .vs_ov_i,
    .vs_ld_i, .vs_ol_low_i, .vs_absent_i, .bat_uv_i, .cp_uv_i, .mode_o,
    .relay_mode_o, .serial_proto_o, .temp_comp_o, .power_reg_o, .switch_on_o,
    .relay_on_o, .ol_enable_o, .uv_fail_o, .ov_fail_o, .bat_uv_fail_o,
    .cp_uv_fail_o, .ci_fall_o, .meas_valid_o, .on_time_o, .period_o);
  gpc_ecu_model u_ecu (.sys_clk_i, .en_i(ecu_en), .low_i(lo), .high_i(hi),
    .ci_o(ecu_ci));
  ////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    if (n_errors == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask
  task automatic do_reset(input logic [3:0] s);
    {ms_open_i, ms_cur_i, bat_present_i, io_cur_i} = s;
    rst_n_i = 1'b0;
    cyc(8);
    rst_n_i = 1'b1;
    cyc(14);
  endtask
  task automatic set_in(ref logic s, input logic v);
    s = v;
    cyc(VF + 12);
  endtask
  // sel high counts switch_on_o, low counts relay_on_o
  task automatic count(input logic sel, input int n, output logic [31:0] c);
    c = 32'h0000_0000;
    repeat (n) begin
      cyc(1);
      c += {31'h0000_0000, sel ? switch_on_o : relay_on_o};
    end
  endtask
  task automatic wait_meas();
    int i;
    for (i = 0; i < 500 && meas_valid_o !== 1'b1; i++) cyc(1);
    if (i == 500) begin
      n_errors++;
      $display("[FAIL] %0t no measurement", $time);
      finish_test();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_modes();
    logic [3:0] st [6] = '{4'h0, 4'h2, 4'h7, 4'h6, 4'hB, 4'hA};
    for (int m = 1; m <= 6; m++) begin
      do_reset(st[m-1]);
      chk(mode_o, m);
      chk(relay_mode_o, m < 3);
      chk(serial_proto_o, m != 1);
      chk(temp_comp_o, m > 4);
      chk(power_reg_o, m == 4 || m == 6);
    end
  endtask
  task automatic t_relay1();
    do_reset(4'h0);
    ci_drv = 1'b0;
    cyc(14);
    chk(relay_on_o, 1);
    ci_drv = 1'b1;
    cyc(14);
    chk(relay_on_o, 0);
    ci_drv = 1'b0;
    cyc(2);
    ci_drv = 1'b1;
    repeat (12) begin
      cyc(1);
      chk(relay_on_o, 0);
    end
  endtask
  task automatic run2(input logic [15:0] l, h, input int lb, ub);
    logic [31:0] c;
    lo = l;
    hi = h;
    ecu_en = 1'b1;
    cyc(250);
    count(1'b0, 480, c);
    chk(c >= lb && c <= ub, 1);
    ecu_en = 1'b0;
    cyc(250);
  endtask
  task automatic t_relay2();
    do_reset(4'h2);
    run2(16'h000A, 16'h0078, 0, 0);
    run2(16'h0078, 16'h000A, 480, 480);
    run2(16'h0078, 16'h0078, 200, 280);
  endtask
  task automatic t_trans();
    logic [31:0] c;
    do_reset(4'h7);
    lo = 16'h0014;
    hi = 16'h001E;
    ecu_en = 1'b1;
    wait_meas();
    cyc(1);
    wait_meas();
    chk(on_time_o, 20);
    chk(period_o, 50);
    count(1'b1, 500, c);
    chk(c, 200);
    ecu_en = 1'b0;
    cyc(TO + 50);
    ci_drv = 1'b0;
    cyc(30);
    chk(switch_on_o, 1);
    cyc(TO + 20);
    chk(switch_on_o, 0);
    ci_drv = 1'b1;
    cyc(TO + 50);
    ci_low_above_override_i = 1'b1;
    ci_drv = 1'b0;
    cyc(TO + 60);
    chk(switch_on_o, 1);
  endtask
  // override pulse holds the switch-on request while supply faults come and go; uv, ov, supply absence and charge pump undervoltage switch the plugs off
  task automatic t_supply();
    set_in(vs_uv_i, 1'b1);
    chk({uv_fail_o, switch_on_o}, 2);
    set_in(vs_uv_i, 1'b0);
    chk({uv_fail_o, switch_on_o}, 1);
    set_in(vs_ov_i, 1'b1);
    chk({ov_fail_o, switch_on_o}, 2);
    set_in(vs_ov_i, 1'b0);
    chk({ov_fail_o, switch_on_o}, 1);
    set_in(bat_uv_i, 1'b1);
    chk(bat_uv_fail_o, 1);
    set_in(bat_uv_i, 1'b0);
    set_in(vs_ol_low_i, 1'b1);
    chk(ol_enable_o, 0);
    set_in(vs_ol_low_i, 1'b0);
    set_in(vs_absent_i, 1'b1);
    chk(switch_on_o, 0);
    set_in(vs_absent_i, 1'b0);
    set_in(cp_uv_i, 1'b1);
    chk({cp_uv_fail_o, switch_on_o}, 2);
    set_in(cp_uv_i, 1'b0);
    chk(switch_on_o, 0);
    ci_drv = 1'b1;
    cyc(20);
    ci_drv = 1'b0;
    cyc(20);
    chk(switch_on_o, 1);
    ci_drv = 1'b1;
    cyc(TO + 50);
    chk(switch_on_o, 0);
    vs_ov_i = 1'b1;
    set_in(vs_ld_i, 1'b1);
    chk(switch_on_o, 1);
    set_in(vs_ld_i, 1'b0);
    chk(switch_on_o, 1);
    set_in(vs_ov_i, 1'b0);
    chk(switch_on_o, 0);
  endtask
  initial begin
    t_modes();
    t_relay1();
    t_relay2();
    t_trans();
    t_supply();
    finish_test();
  end
endmodule
`default_nettype wire
